// ---- verilog/jpe_port.sv ----
/*
 * Enable, pin steering, command decode and status pins of the serial
 * in-system programming port on port E.
 * Assumes the flash engine reports busy as a level and failure as a
 * one-cycle pulse on CLK_SYS; the port E pads resolve the enables.
 */
// Strobed register access was decided locally.
// Summary of operation
// R1: Port pins are active when the nonvolatile, runtime or product-term source is true.
// R2: Once enabled, mode, clock, data-in and data-out pins are all inputs.
// R3: After the enabling command, data-out is driven and the channel works.
// R4: The enabling command may also turn on the status and error pins.
// R5: With no enable source true, the four pins are ordinary port I/O.
// R6: The nonvolatile bit dedicates the pins regardless of runtime state.
// R7: Runtime enable register sits at offset c7; its bit enables the pins.
// R8: The runtime enable bit clears on reset or by a software write.
// R9: A user product term can enable the pins for multiplexed use.
// R10: With the nonvolatile source, reset neither blocks nor aborts port work.
// R11: With the runtime source, reset blocks and aborts port work.
// R12: Only programming commands are implemented; no boundary scan.
// R13: Error pin goes low on failure; cleared by command or reset after exit.
// R14: Status pin high when idle, low while programming, erasing or writing.
// R15: A command switches status and error pins between push-pull and open-drain.
// R16: When secured, no memory read-out is allowed.
// R17: When secured, only full-chip erase is accepted.
// R18: A finished full-chip erase clears security and leaves the device blank.
// R19: Each sector has a protect bit; erasing a protected sector is refused.
// R20: A blank device enables the four basic pins by default.
// R21: Mode, clock, data-in, data-out, status, error sit on port E bits 0 to 5.
// R22: Delivered state: memory reads as ones, configuration bits as zeros.
// R23: Reset clears the runtime enable register to zero.
// R24: Status and error pins stay ordinary I/O until their enable is commanded.
`timescale 1ns/1ps
module jpe_port import jpe_pkg::*; #(
	parameter int SECTORS = SECTOR_COUNT
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic POWER_ON_RESET,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// Enable sources and configuration
	input wire logic NVM_DEDICATE,
	input wire logic PIN_SELECT_TERM,
	input wire logic DEVICE_BLANK,
	input wire logic SECURE_CONFIG,
	input wire logic [SECTORS-1:0] SECTOR_PROTECT_CONFIG,
	// Port E pads
	input wire logic [PORT_E_WIDTH-1:0] PORT_E_IN,
	output logic [PORT_E_WIDTH-1:0] PORT_E_OUT,
	output logic [PORT_E_WIDTH-1:0] PORT_E_OE,
	// General port logic
	input wire logic [PORT_E_WIDTH-1:0] GPIO_OUT,
	input wire logic [PORT_E_WIDTH-1:0] GPIO_OE,
	output logic [PORT_E_WIDTH-1:0] GPIO_IN,
	// Flash engine
	output logic FLASH_START,
	output logic [2:0] FLASH_OP,
	output logic [4:0] FLASH_SECTOR,
	input wire logic FLASH_BUSY,
	input wire logic FLASH_FAIL,
	input wire logic [7:0] FLASH_RDATA
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Every pad is filtered, port logic included, so no half-settled level leaks inward
	logic [SYNC_STAGES-1:0] sync_reg [PORT_E_WIDTH];
	logic [PORT_E_WIDTH-1:0] pin_reg;
	genvar gi;
	generate
		for (gi = 0; gi < PORT_E_WIDTH; gi++) begin : g_sync
			always_ff @(posedge CLK_SYS) begin
				if (POWER_ON_RESET) begin
					sync_reg[gi] <= '0;
					pin_reg[gi] <= 1'b0;
				end else begin
					sync_reg[gi] <= {sync_reg[gi][SYNC_STAGES-2:0], PORT_E_IN[gi]};
					// Second and third stage must agree before a change counts
					if (sync_reg[gi][1] == sync_reg[gi][2]) begin
						pin_reg[gi] <= sync_reg[gi][2];
					end
				end
			end
		end
	endgenerate

	logic tms, tck, tdi;
	assign tms = pin_reg[PIN_MODE]; // R21
	assign tck = pin_reg[PIN_CLOCK]; // R21
	assign tdi = pin_reg[PIN_DIN]; // R21

	logic tck_d_reg;
	logic tck_rise, tck_fall;
	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET) begin
			tck_d_reg <= 1'b0;
		end else begin
			tck_d_reg <= tck;
		end
	end
	assign tck_rise = tck & ~tck_d_reg;
	assign tck_fall = ~tck & tck_d_reg;

	// ****************************************************************
	// Enable sources
	// ****************************************************************
	logic run_enable_reg;
	logic secure_reg;
	logic [SECTORS-1:0] protect_reg;
	logic blank_reg;
	logic port_on;
	logic run_only;
	// Reset stops port work whenever the nonvolatile bit is clear, whichever other source turned it on
	assign port_on = NVM_DEDICATE | run_enable_reg | PIN_SELECT_TERM | blank_reg; // R1 R6 R9 R20
	assign run_only = ~NVM_DEDICATE; // R10 R11

	logic port_hold;
	assign port_hold = POWER_ON_RESET | (RESET & run_only) | ~port_on; // R10 R11

	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET | RESET) begin
			run_enable_reg <= RUN_ENABLE_RESET[RUN_ENABLE_BIT]; // R8 R23
		end else if (REG_WR && REG_ADDR == ADDR_RUN_ENABLE) begin
			run_enable_reg <= REG_WDATA[RUN_ENABLE_BIT]; // R7 R8
		end
	end

	// ****************************************************************
	// Serial command shifter
	// ****************************************************************
	logic [CMD_WIDTH-1:0] shift_reg;
	logic [CMD_WIDTH-1:0] out_reg;
	logic tms_d_reg;
	logic exec;
	jpe_opcode_e opc;
	logic [4:0] arg;

	always_ff @(posedge CLK_SYS) begin
		if (port_hold) begin
			shift_reg <= '0;
			tms_d_reg <= 1'b0;
		end else if (tck_rise) begin
			tms_d_reg <= tms;
			if (!tms) begin
				shift_reg <= {tdi, shift_reg[CMD_WIDTH-1:1]};
			end
		end
	end
	// A command executes on the first clock rise with mode select high
	assign exec = tck_rise & tms & ~tms_d_reg & ~port_hold;
	assign opc = jpe_opcode_e'(shift_reg[7:5]);
	assign arg = shift_reg[4:0];

	// ****************************************************************
	// Channel state
	// ****************************************************************
	logic chan_reg, ext_reg, open_drain_reg, exit_seen_reg, err_reg, refused_reg;
	logic erase_all_reg, busy_d_reg;
	logic allowed;
	logic sector_ok;
	assign sector_ok = (arg < 5'(SECTORS)) && !protect_reg[arg]; // R19
	always_comb begin
		allowed = 1'b1;
		if (secure_reg && opc != OPC_FULL_ERASE && opc != OPC_ENABLE
			&& opc != OPC_CLEAR_ERR && opc != OPC_DRIVE_MODE && opc != OPC_EXIT_CONFIG) begin
			allowed = 1'b0; // R16 R17
		end
		if (opc == OPC_SECTOR_ERASE && !sector_ok) begin
			allowed = 1'b0; // R19
		end
		if (!chan_reg && opc != OPC_ENABLE) begin
			allowed = 1'b0; // R2
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (port_hold) begin
			chan_reg <= 1'b0;
			ext_reg <= 1'b0;
			open_drain_reg <= 1'b0;
		end else if (exec) begin
			unique case (opc)
				OPC_ENABLE: begin
					chan_reg <= 1'b1; // R3
					ext_reg <= arg[0]; // R4 R24
				end
				OPC_DRIVE_MODE: begin
					if (chan_reg) begin
						open_drain_reg <= arg[0]; // R15
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (port_hold) begin
			exit_seen_reg <= 1'b0;
		end else if (exec && chan_reg && opc == OPC_EXIT_CONFIG) begin
			exit_seen_reg <= 1'b1;
		end
	end

	// Error: a failure in the same cycle as a clear keeps the flag set
	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET) begin
			err_reg <= 1'b0;
		end else if (FLASH_FAIL) begin
			err_reg <= 1'b1; // R13
		end else if (RESET && exit_seen_reg) begin
			err_reg <= 1'b0; // R13
		end else if (exec && chan_reg && opc == OPC_CLEAR_ERR) begin
			err_reg <= 1'b0; // R13
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (port_hold) begin
			refused_reg <= 1'b0;
		end else if (exec) begin
			refused_reg <= ~allowed;
		end
	end

	// ****************************************************************
	// Flash requests and security
	// ****************************************************************
	logic flash_cmd;
	assign flash_cmd = opc == OPC_FULL_ERASE || opc == OPC_SECTOR_ERASE
		|| opc == OPC_PROGRAM || opc == OPC_READ;

	always_ff @(posedge CLK_SYS) begin
		if (port_hold) begin
			FLASH_START <= 1'b0;
			FLASH_OP <= 3'h0;
			FLASH_SECTOR <= SECTOR_RESET;
		end else begin
			FLASH_START <= exec && allowed && flash_cmd && !FLASH_BUSY; // R12 R16 R17 R19
			if (exec && allowed && flash_cmd) begin
				FLASH_OP <= shift_reg[7:5];
				FLASH_SECTOR <= arg;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (port_hold) begin
			erase_all_reg <= 1'b0;
		end else if (FLASH_START) begin
			erase_all_reg <= FLASH_OP == 3'(OPC_FULL_ERASE);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET) begin
			busy_d_reg <= 1'b0;
		end else begin
			busy_d_reg <= FLASH_BUSY;
		end
	end

	logic erase_done;
	assign erase_done = busy_d_reg & ~FLASH_BUSY & erase_all_reg & ~FLASH_FAIL;

	// Configuration is caught one edge after power-on release, not under reset
	logic load_reg;
	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET) begin
			load_reg <= 1'b1;
		end else begin
			load_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET) begin
			secure_reg <= 1'b0; // R22
			protect_reg <= '0; // R22
			blank_reg <= 1'b0;
		end else if (load_reg) begin
			secure_reg <= SECURE_CONFIG;
			protect_reg <= SECTOR_PROTECT_CONFIG;
			blank_reg <= DEVICE_BLANK;
		end else if (erase_done) begin
			secure_reg <= 1'b0; // R18
			protect_reg <= '0; // R18
			blank_reg <= 1'b1; // R18 R20
		end
	end

	// ****************************************************************
	// Serial read-back
	// ****************************************************************
	logic [7:0] status_word;
	assign status_word = {1'b0, refused_reg, FLASH_BUSY, err_reg, secure_reg, ext_reg, chan_reg, port_on};

	always_ff @(posedge CLK_SYS) begin
		if (port_hold) begin
			out_reg <= '0;
		end else if (exec) begin
			// Memory data only leaves the part when unsecured
			out_reg <= (opc == OPC_READ && allowed) ? FLASH_RDATA : status_word; // R16
		end else if (tck_fall && !tms) begin
			out_reg <= {1'b0, out_reg[CMD_WIDTH-1:1]};
		end
	end

	// ****************************************************************
	// Port E pin steering
	// ****************************************************************
	logic stat_level, err_level;
	assign stat_level = ~FLASH_BUSY; // R14
	assign err_level = ~err_reg; // R13

	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET) begin
			PORT_E_OUT <= '0;
			PORT_E_OE <= '0;
			GPIO_IN <= '0;
		end else begin
			PORT_E_OUT <= GPIO_OUT;
			PORT_E_OE <= GPIO_OE; // R5
			GPIO_IN <= pin_reg;
			if (port_on) begin
				PORT_E_OE[PIN_DOUT:PIN_MODE] <= 4'h0; // R2 R6
				GPIO_IN[PIN_DOUT:PIN_MODE] <= 4'h0;
				PORT_E_OUT[PIN_DOUT:PIN_MODE] <= 4'h0;
				if (chan_reg) begin
					PORT_E_OUT[PIN_DOUT] <= out_reg[0]; // R3
					PORT_E_OE[PIN_DOUT] <= 1'b1; // R3
				end
				if (ext_reg) begin
					PORT_E_OUT[PIN_STATUS] <= open_drain_reg ? 1'b0 : stat_level; // R14 R15
					PORT_E_OE[PIN_STATUS] <= open_drain_reg ? ~stat_level : 1'b1; // R15
					PORT_E_OUT[PIN_ERROR] <= open_drain_reg ? 1'b0 : err_level; // R13 R15
					PORT_E_OE[PIN_ERROR] <= open_drain_reg ? ~err_level : 1'b1; // R15
					GPIO_IN[PIN_ERROR:PIN_STATUS] <= 2'h0; // R24
				end
			end
		end
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (POWER_ON_RESET | RESET) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				ADDR_RUN_ENABLE: REG_RDATA <= {7'h00, run_enable_reg}; // R7
				ADDR_PORT_STATUS: REG_RDATA <= status_word;
				default: REG_RDATA <= 8'h00;
			endcase
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (POWER_ON_RESET);

	run_bit_clear_a: assert property (RESET |=> !run_enable_reg) // R8
		else $error("runtime enable survived reset");
	run_bit_write_a: assert property (REG_WR && REG_ADDR == 8'hc7 && !RESET |=> run_enable_reg == $past(REG_WDATA[0])) // R7
		else $error("runtime enable write lost");
	enable_or_a: assert property (NVM_DEDICATE || run_enable_reg || PIN_SELECT_TERM |=> PORT_E_OE[2:0] == 3'h0) // R1
		else $error("enable sources not ORed");
	dout_idle_a: assert property (port_on && !chan_reg |=> !PORT_E_OE[3]) // R2
		else $error("data-out driven before enable");
	dout_drive_a: assert property (port_on && chan_reg && !port_hold |=> PORT_E_OE[3]) // R3
		else $error("data-out not driven after enable");
	gpio_release_a: assert property (!port_on |=> PORT_E_OE[3:0] == $past(GPIO_OE[3:0])) // R5
		else $error("pins not released to port logic");
	nvm_reset_a: assert property (NVM_DEDICATE && chan_reg && RESET ##1 NVM_DEDICATE |-> chan_reg) // R10
		else $error("reset aborted dedicated port");
	run_reset_a: assert property (!NVM_DEDICATE && RESET |=> !chan_reg) // R11
		else $error("reset did not abort runtime port");
	err_set_a: assert property (FLASH_FAIL |=> err_reg ##1 (err_reg || $past(RESET) || $past(exec))) // R13
		else $error("error flag not held");
	secure_block_a: assert property (secure_reg && exec && opc == OPC_PROGRAM |=> !FLASH_START) // R17
		else $error("program accepted while secured");
	protect_a: assert property (exec && opc == OPC_SECTOR_ERASE && protect_reg[arg] |=> !FLASH_START) // R19
		else $error("protected sector erased");
	ext_off_a: assert property (!ext_reg ##1 1 |-> PORT_E_OE[5:4] == $past(GPIO_OE[5:4])) // R24
		else $error("extension pins taken without command");

	enable_seen_c: cover property (exec && opc == OPC_ENABLE ##[1:4] PORT_E_OE[3]);
	erase_done_c: cover property (secure_reg ##[1:1000] erase_done);
	fail_clear_c: cover property (err_reg ##[1:1000] !err_reg);
	open_drain_c: cover property (open_drain_reg && ext_reg);

endmodule : jpe_port

// ---- verilog/jpe_pkg.sv ----
/*
 * Shared constants of the test-port enable block: register map, field
 * positions, reset values, serial command encodings and link timing.
 * Assumes an 8-bit register port and a 40 MHz system clock.
 */
package jpe_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_RUN_ENABLE = 8'hc7;
	localparam logic [7:0] ADDR_PORT_STATUS = 8'hc8;
	localparam int RUN_ENABLE_BIT = 0;
	localparam logic [7:0] RUN_ENABLE_RESET = 8'h00;
	localparam int STAT_ON_BIT = 0;
	localparam int STAT_CHAN_BIT = 1;
	localparam int STAT_EXT_BIT = 2;
	localparam int STAT_SECURE_BIT = 3;
	localparam int STAT_ERR_BIT = 4;
	localparam int STAT_BUSY_BIT = 5;
	localparam int STAT_REFUSED_BIT = 6;

	// ****************************************************************
	// Port E bit assignment
	// ****************************************************************
	localparam int PIN_MODE = 0;
	localparam int PIN_CLOCK = 1;
	localparam int PIN_DIN = 2;
	localparam int PIN_DOUT = 3;
	localparam int PIN_STATUS = 4;
	localparam int PIN_ERROR = 5;
	localparam int PORT_E_WIDTH = 6;

	// ****************************************************************
	// Serial commands: opcode in bits 7:5, argument in bits 4:0
	// ****************************************************************
	typedef enum logic [2:0] {
		OPC_ENABLE, OPC_CLEAR_ERR, OPC_DRIVE_MODE, OPC_FULL_ERASE,
		OPC_SECTOR_ERASE, OPC_PROGRAM, OPC_READ, OPC_EXIT_CONFIG
	} jpe_opcode_e;
	localparam int CMD_WIDTH = 8;
	localparam int SECTOR_COUNT = 20;
	localparam logic [4:0] SECTOR_RESET = 5'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int SYNC_STAGES = 3;

endpackage : jpe_pkg

// ---- testbench/jpe_ctrl_model.sv ----
/*
 * Behavioural external programming controller on the port E link.
 * Assumes the bench resolves the pads and feeds data-out back in.
 */
`timescale 1ns/1ps
module jpe_ctrl_model (
	// Link pins
	output logic mode,
	output logic tck,
	output logic tdi,
	// Returned data
	input wire logic tdo
);
	logic [7:0] rx;

	initial begin
		mode = 1'b1;
		tck = 1'b0;
		tdi = 1'b0;
		rx = 8'h00;
	end

	// ****************************************************************
	// One frame: eight bits LSB first, then a rise with mode high
	// ****************************************************************
	// Clock stands still between frames; 100 ns per level keeps four system cycles per level
	task automatic send(input logic [7:0] cmd);
		mode = 1'b0;
		for (int i = 0; i < 8; i++) begin
			tdi = cmd[i];
			#100 tck = 1'b1;
			// Data-out moves some system cycles after each fall, so take it just before the next fall
			#100 rx[i] = tdo;
			tck = 1'b0;
		end
		mode = 1'b1;
		// Data-in is stale once the frame ends
		tdi = ~tdi;
		#100 tck = 1'b1;
		#100 tck = 1'b0;
	endtask : send
endmodule : jpe_ctrl_model

// ---- testbench/jtag_isp_port_enable_test.sv ----
/*
 * Self-checking bench of the port E programming-port block.
 * Assumes a pull-up on port E bits 3 to 5 and a controller model on bits 0 to 2.
 */
`timescale 1ns/1ps
module jtag_isp_port_enable_test;
	import jpe_pkg::*;
	logic clk_sys, reset, por, reg_wr, reg_rd, nvm, pts, blank, secure, busy, fail, flash_start;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, flash_rdata, v;
	logic [SECTOR_COUNT-1:0] protect;
	logic [PORT_E_WIDTH-1:0] pe_in, pe_out, pe_oe, gpio_out, gpio_oe, gpio_in;
	logic [2:0] flash_op;
	logic [4:0] flash_sector;
	logic mode, tck, tdi;
	int failures = 0;
	int n_compared = 0;
	int n_start = 0;
	int s;

	// Driven pins win; otherwise the controller or the pull-up sets the level
	assign pe_in = (pe_oe & pe_out) | (~pe_oe & {3'b111, tdi, tck, mode});

	jpe_port DUT (.CLK_SYS(clk_sys), .RESET(reset), .POWER_ON_RESET(por), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.NVM_DEDICATE(nvm), .PIN_SELECT_TERM(pts), .DEVICE_BLANK(blank), .SECURE_CONFIG(secure),
		.SECTOR_PROTECT_CONFIG(protect), .PORT_E_IN(pe_in), .PORT_E_OUT(pe_out), .PORT_E_OE(pe_oe),
		.GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .GPIO_IN(gpio_in), .FLASH_START(flash_start),
		.FLASH_OP(flash_op), .FLASH_SECTOR(flash_sector), .FLASH_BUSY(busy), .FLASH_FAIL(fail),
		.FLASH_RDATA(flash_rdata));
	jpe_ctrl_model ctrl (.mode(mode), .tck(tck), .tdi(tdi), .tdo(pe_in[PIN_DOUT]));

	initial begin
		clk_sys = 1'b0;
		forever #(CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (flash_start === 1'b1) begin
			n_start <= n_start + 1;
		end
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		// Data stand for the cycle after the strobe; take them at the edge that ends it
		@(posedge clk_sys);
		d = reg_rdata;
	endtask : rd
	task automatic cmd(input jpe_opcode_e op, input logic [4:0] arg);
		ctrl.send({op, arg});
		cyc(8);
	endtask : cmd
	task automatic por_cycle(input logic b, input logic sec, input logic n);
		blank <= b;
		secure <= sec;
		nvm <= n;
		por <= 1'b1;
		reset <= 1'b1;
		cyc(16);
		por <= 1'b0;
		reset <= 1'b0;
		cyc(2);
	endtask : por_cycle
	task automatic warm_reset;
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		cyc(2);
	endtask : warm_reset
	task automatic fail_pulse;
		@(posedge clk_sys);
		fail <= 1'b1;
		@(posedge clk_sys);
		fail <= 1'b0;
		cyc(3);
	endtask : fail_pulse
	task automatic close_out;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_blank;
		por_cycle(1'b1, 1'b0, 1'b0);
		rd(ADDR_PORT_STATUS, v);
		chk(8'(v[STAT_ON_BIT]), 8'h1);
		rd(ADDR_RUN_ENABLE, v);
		chk(v, RUN_ENABLE_RESET);
		$display("test blank done");
	endtask : t_blank
	task automatic t_sources;
		por_cycle(1'b0, 1'b0, 1'b0);
		chk(8'(pe_oe[3:0]), 8'(gpio_oe[3:0]));
		chk(8'(pe_out[3:0]), 8'(gpio_out[3:0]));
		for (int k = 0; k < 3; k++) begin
			nvm <= (k == 0);
			pts <= (k == 1);
			wr(ADDR_RUN_ENABLE, (k == 2) ? 8'hff : 8'h00);
			cyc(2);
			rd(ADDR_PORT_STATUS, v);
			chk(8'(v[STAT_ON_BIT]), 8'h1);
			chk(8'(pe_oe[3:0]), 8'h0);
			chk(8'(gpio_in[3:0]), 8'h0);
		end
		rd(ADDR_RUN_ENABLE, v);
		chk(v, 8'h01);
		wr(ADDR_RUN_ENABLE, 8'h00);
		rd(ADDR_RUN_ENABLE, v);
		chk(v, 8'h00);
		rd(8'hc9, v);
		chk(v, 8'h00);
		rd(ADDR_PORT_STATUS, v);
		chk(8'(v[STAT_ON_BIT]), 8'h0);
		chk(8'(gpio_in), 8'h11);
		$display("test sources done");
	endtask : t_sources
	task automatic t_enable;
		wr(ADDR_RUN_ENABLE, 8'h01);
		s = n_start;
		cmd(OPC_FULL_ERASE, 5'h00);
		chk(8'(n_start - s), 8'h0);
		chk(8'(pe_oe[PIN_DOUT]), 8'h0);
		cmd(OPC_ENABLE, 5'h00);
		chk(8'(pe_oe[PIN_DOUT]), 8'h1);
		chk(8'(pe_oe[5:4]), 8'(gpio_oe[5:4]));
		chk(8'(gpio_in[5:4]), 8'h1);
		cmd(OPC_ENABLE, 5'h01);
		chk(ctrl.rx, 8'h41);
		chk(8'(pe_oe[5:4]), 8'h3);
		chk(8'(gpio_in[5:4]), 8'h0);
		chk(8'(pe_out[5:4]), 8'h3);
		warm_reset;
		chk(8'(pe_oe[PIN_DOUT]), 8'(gpio_oe[PIN_DOUT]));
		rd(ADDR_RUN_ENABLE, v);
		chk(v, 8'h00);
		$display("test enable done");
	endtask : t_enable
	task automatic t_flash;
		nvm <= 1'b1;
		cmd(OPC_ENABLE, 5'h01);
		s = n_start;
		cmd(OPC_SECTOR_ERASE, 5'h03);
		chk(8'(n_start - s), 8'h1);
		chk(8'({flash_op, flash_sector}), 8'h83);
		cmd(OPC_SECTOR_ERASE, 5'h05);
		cmd(OPC_SECTOR_ERASE, 5'h14);
		chk(8'(n_start - s), 8'h1);
		rd(ADDR_PORT_STATUS, v);
		chk(8'(v[STAT_REFUSED_BIT]), 8'h1);
		busy <= 1'b1;
		cyc(3);
		chk(8'(pe_out[PIN_STATUS]), 8'h0);
		fail_pulse;
		busy <= 1'b0;
		cyc(3);
		chk(8'(pe_out[5:4]), 8'h1);
		cmd(OPC_CLEAR_ERR, 5'h00);
		chk(8'(pe_out[PIN_ERROR]), 8'h1);
		cmd(OPC_DRIVE_MODE, 5'h01);
		chk(8'({pe_out[5:4], pe_oe[5:4]}), 8'h0);
		busy <= 1'b1;
		fail_pulse;
		chk(8'(pe_oe[5:4]), 8'h3);
		busy <= 1'b0;
		warm_reset;
		chk(8'(pe_oe[PIN_DOUT]), 8'h1);
		rd(ADDR_PORT_STATUS, v);
		chk(8'(v[STAT_ERR_BIT]), 8'h1);
		cmd(OPC_EXIT_CONFIG, 5'h00);
		warm_reset;
		rd(ADDR_PORT_STATUS, v);
		chk(8'(v[STAT_ERR_BIT]), 8'h0);
		$display("test flash done");
	endtask : t_flash
	task automatic t_secure;
		por_cycle(1'b0, 1'b1, 1'b1);
		cmd(OPC_ENABLE, 5'h00);
		rd(ADDR_PORT_STATUS, v);
		chk(8'(v[STAT_SECURE_BIT]), 8'h1);
		s = n_start;
		cmd(OPC_READ, 5'h00);
		cmd(OPC_PROGRAM, 5'h00);
		chk(ctrl.rx, 8'h0b);
		cmd(OPC_SECTOR_ERASE, 5'h03);
		chk(8'(n_start - s), 8'h0);
		cmd(OPC_FULL_ERASE, 5'h00);
		chk(8'(n_start - s), 8'h1);
		chk(8'(flash_op), 8'h3);
		busy <= 1'b1;
		cyc(4);
		busy <= 1'b0;
		cyc(4);
		rd(ADDR_PORT_STATUS, v);
		chk(8'(v[STAT_SECURE_BIT]), 8'h0);
		cmd(OPC_READ, 5'h00);
		cmd(OPC_SECTOR_ERASE, 5'h05);
		chk(ctrl.rx, flash_rdata);
		chk(8'(n_start - s), 8'h3);
		cmd(OPC_PROGRAM, 5'h07);
		chk(8'(n_start - s), 8'h4);
		chk(8'({flash_op, flash_sector}), 8'ha7);
		$display("test secure done");
	endtask : t_secure

	initial begin
		{reset, por} = 2'b11;
		{reg_wr, reg_rd, nvm, pts, blank, secure, busy, fail} = 8'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		flash_rdata = 8'ha5;
		protect = 20'h00020;
		gpio_out = 6'h15;
		gpio_oe = 6'h2a;
		t_blank;
		t_sources;
		t_enable;
		t_flash;
		t_secure;
		close_out;
	end
	initial begin
		cyc(40000);
		failures++;
		close_out;
	end
endmodule : jtag_isp_port_enable_test
